// ===== design/dmcr_pkg.sv
// dmcr_pkg: register map, reset values and field positions of the
// misc control register group of the video digitizer.
// assumes nothing beyond a sv-2012 compiler.
`default_nettype none
package dmcr_pkg;
   // subaddresses
   localparam logic [7:0] MISC_CONTROL_ONE_ADDR = 8'h16;
   localparam logic [7:0] MISC_CONTROL_TWO_ADDR = 8'h17;
   localparam logic [7:0] MISC_CONTROL_THREE_ADDR = 8'h18;
   localparam logic [7:0] INPUT_MUX_SELECT_ONE_ADDR = 8'h19;
   localparam logic [7:0] FILTER_CLOCK_SYNC_SELECT_ADDR = 8'h1a;
   // reset values
   localparam logic [7:0] MISC_CONTROL_ONE_RST = 8'h11;
   localparam logic [7:0] MISC_CONTROL_TWO_RST = 8'h03;
   localparam logic [7:0] MISC_CONTROL_THREE_RST = 8'h00;
   localparam logic [7:0] INPUT_MUX_SELECT_ONE_RST = 8'h00;
   localparam logic [7:0] FILTER_CLOCK_SYNC_SELECT_RST = 8'hc2;
   // writable bit masks, reserved bits read as zero
   localparam logic [7:0] MISC_CONTROL_ONE_MASK = 8'h13;
   localparam logic [7:0] MISC_CONTROL_TWO_MASK = 8'h73;
   localparam logic [7:0] MISC_CONTROL_THREE_MASK = 8'h37;
   localparam logic [7:0] INPUT_MUX_SELECT_ONE_MASK = 8'hff;
   localparam logic [7:0] FILTER_CLOCK_SYNC_SELECT_MASK = 8'hff;
   // misc control one fields
   localparam int STARTUP_BIT = 0;
   localparam int POWERDOWN_BIT = 1;
   localparam int ALIGN_BIT = 4;
   // misc control two fields
   localparam int OUT_EN_N_BIT = 0;
   localparam int GREEN_OUT_EN_N_BIT = 1;
   localparam int TEST_SEL_LSB = 4;
   // misc control three fields
   localparam int CLK_EDGE_BIT = 0;
   localparam int GREEN_INV_BIT = 1;
   localparam int FIELD_INV_BIT = 2;
   localparam int CONVERT_EN_BIT = 4;
   localparam int BLANK_EN_BIT = 5;
   // input mux fields
   localparam int BLUE_SEL_LSB = 0;
   localparam int GREEN_SEL_LSB = 2;
   localparam int RED_SEL_LSB = 4;
   localparam int GSYNC_SEL_LSB = 6;
   // filter, clock and sync select fields
   localparam int HSYNC_PICK_BIT = 0;
   localparam int PCLK_SEL_BIT = 1;
   localparam int VSYNC_PICK_BIT = 2;
   localparam int CLK_SEL_BIT = 3;
   localparam int CLAMP_LPF_LSB = 4;
   localparam int GSYNC_LPF_LSB = 6;
   // standard blank levels for a 10 bit luma and chroma sample
   localparam logic [9:0] BLANK_LUMA = 10'h040;
   localparam logic [9:0] BLANK_CHROMA = 10'h200;
   // test pin selector codes
   typedef enum logic [2:0] {
      DMCR_TP_FIELD = 3'b000,
      DMCR_TP_DATA_EN = 3'b001,
      DMCR_TP_RSVD2 = 3'b010,
      DMCR_TP_RSVD3 = 3'b011,
      DMCR_TP_REFCLK = 3'b100,
      DMCR_TP_COAST = 3'b101,
      DMCR_TP_CLAMP = 3'b110,
      DMCR_TP_HIZ = 3'b111
   } dmcr_test_sel_e;
endpackage
`default_nettype wire

// ===== design/dmcr_regs.sv
// dmcr_regs: misc control register group of the digitizer, with the
// output enables, polarity controls, test pin selector and sync selects.
// assumes a serial control engine that presents subaddress level writes
// and reads, and same-clock video timing signals from the sync processor.
// the pin pads and three-state drivers sit outside; each _oe is high to drive.
// all flops share one clock and a synchronous reset; clk_en low freezes them.
//
// Functional notes
// - alignment bit one selects normal chroma pairing, zero the alternative.
// - powerdown bit one powers the line pll down, zero runs it.
// - startup bit one enables the line pll startup circuit.
// - three bit code selects field, data enable, refclock, coast, clamp or hi-z.
// - green sync output driven when its low-active enable is zero.
// - data, clock, syncs and field outputs driven only when enable is zero.
// - data enable equals active video window outside vertical blanking.
// - blank enable forces standard blank levels outside data enable while embedded syncs used.
// - colour converter output used when enabled, bypassed otherwise.
// - field flag is one on odd field, inverted by field polarity bit.
// - field polarity bit also inverts data enable on the test pin.
// - green sync polarity bit one inverts the green sync output.
// - clock edge bit zero gives rising edge data, one falling edge.
// - four two-bit fields select analog inputs; green code 11 is input four.
// - green sync filter: 2.5, 10, 33 MHz or bypass by default.
// - coarse clamp filter: 4.8 default, 0.5, 1.7 MHz, code 11 reserved.
// - sync reference is internal oscillator at zero, external clock at one.
// - control port, separator and detectors always use the internal reference.
// - vertical sync select zero picks input a, one picks input b.
// - converter sample clock is line pll at one, external clock at zero.
// - horizontal sync select zero picks input a, one picks input b.
`default_nettype none
module dmcr_regs
   import dmcr_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // subaddress register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_addr_hit,
   // same-clock video timing from sync processing
   input wire logic odd_field,
   input wire logic active_video_window,
   input wire logic vertical_blank_window,
   input wire logic internal_ref_clock,
   input wire logic coast,
   input wire logic clamp_pulse,
   input wire logic embedded_sync_enable,
   input wire logic horizontal_sync_proc,
   input wire logic vertical_sync_proc,
   input wire logic green_sync_proc,
   input wire logic sample_clock_phase,
   input wire logic [29:0] pixel_in,
   input wire logic [29:0] converted_pixel_in,
   // sync pins from outside
   input wire logic hsync_a_pin,
   input wire logic hsync_b_pin,
   input wire logic vsync_a_pin,
   input wire logic vsync_b_pin,
   // three-state outputs
   output logic [29:0] pixel_data_out,
   output logic pixel_data_oe,
   output logic output_data_clock,
   output logic output_data_clock_oe,
   output logic horizontal_sync_output,
   output logic horizontal_sync_oe,
   output logic vertical_sync_output,
   output logic vertical_sync_oe,
   output logic field_flag_output,
   output logic field_flag_oe,
   output logic green_sync_output,
   output logic green_sync_oe,
   output logic test_pin_out,
   output logic test_pin_oe,
   // control levels to analog and clock blocks
   output logic chroma_pair_alignment,
   output logic line_pll_powerdown,
   output logic line_pll_startup_enable,
   output logic color_convert_enable,
   output logic [1:0] green_sync_input_select,
   output logic [1:0] red_input_select,
   output logic [1:0] green_input_select,
   output logic [1:0] blue_input_select,
   output logic [1:0] green_sync_filter_select,
   output logic [1:0] coarse_clamp_filter_select,
   output logic sync_ref_external,
   output logic sample_clock_from_pll,
   output logic selected_hsync,
   output logic selected_vsync
);

   logic [7:0] misc_control_one_reg;
   logic [7:0] misc_control_two_reg;
   logic [7:0] misc_control_three_reg;
   logic [7:0] input_mux_select_one_reg;
   logic [7:0] filter_clock_sync_select_reg;
   logic [3:0] sync_meta_reg;
   logic [3:0] sync_pin_reg;
   logic [29:0] pixel_data_reg;
   logic field_flag_reg;
   logic horizontal_sync_reg;
   logic vertical_sync_reg;
   logic green_sync_reg;
   logic test_pin_reg;

   // next values of the video and test pin registers
   logic [29:0] pixel_data_next;
   logic test_pin_next;

   // reserved bits are dropped on write and read back as zero
   function automatic logic [7:0] masked_write(input logic [7:0] data, input logic [7:0] mask);
      masked_write = data & mask;
   endfunction

   // test codes that put a signal on the test pin
   function automatic logic test_code_driven(input logic [2:0] code);
      case (dmcr_test_sel_e'(code))
         DMCR_TP_FIELD, DMCR_TP_DATA_EN, DMCR_TP_REFCLK: test_code_driven = 1'b1;
         DMCR_TP_COAST, DMCR_TP_CLAMP: test_code_driven = 1'b1;
         default: test_code_driven = 1'b0;
      endcase
   endfunction

   // address decode
   wire sel_one = (reg_addr == MISC_CONTROL_ONE_ADDR);
   wire sel_two = (reg_addr == MISC_CONTROL_TWO_ADDR);
   wire sel_three = (reg_addr == MISC_CONTROL_THREE_ADDR);
   wire sel_mux = (reg_addr == INPUT_MUX_SELECT_ONE_ADDR);
   wire sel_fcs = (reg_addr == FILTER_CLOCK_SYNC_SELECT_ADDR);
   wire wr_ok = reg_write & clk_en;

   // per-register write strobes, a frozen clock enable drops the write
   // unmapped subaddresses match no strobe and are ignored
   wire wr_one = wr_ok & sel_one;
   wire wr_two = wr_ok & sel_two;
   wire wr_three = wr_ok & sel_three;
   wire wr_mux = wr_ok & sel_mux;
   wire wr_fcs = wr_ok & sel_fcs;

   // misc control one
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         misc_control_one_reg <= MISC_CONTROL_ONE_RST;
      end else if (wr_one) begin
         misc_control_one_reg <= masked_write(reg_wdata, MISC_CONTROL_ONE_MASK);
      end
   end

   // misc control two
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         misc_control_two_reg <= MISC_CONTROL_TWO_RST;
      end else if (wr_two) begin
         misc_control_two_reg <= masked_write(reg_wdata, MISC_CONTROL_TWO_MASK);
      end
   end

   // misc control three
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         misc_control_three_reg <= MISC_CONTROL_THREE_RST;
      end else if (wr_three) begin
         misc_control_three_reg <= masked_write(reg_wdata, MISC_CONTROL_THREE_MASK);
      end
   end

   // input mux select
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         input_mux_select_one_reg <= INPUT_MUX_SELECT_ONE_RST;
      end else if (wr_mux) begin
         input_mux_select_one_reg <= masked_write(reg_wdata, INPUT_MUX_SELECT_ONE_MASK);
      end
   end

   // filter, clock and sync select
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         filter_clock_sync_select_reg <= FILTER_CLOCK_SYNC_SELECT_RST;
      end else if (wr_fcs) begin
         filter_clock_sync_select_reg <= masked_write(reg_wdata, FILTER_CLOCK_SYNC_SELECT_MASK);
      end
   end

   // readback, unmapped subaddresses read zero
   // a read has no side effect, so software may poll it freely
   assign reg_addr_hit = sel_one | sel_two | sel_three | sel_mux | sel_fcs;
   assign reg_rdata = ({8{sel_one}} & misc_control_one_reg)
      | ({8{sel_two}} & misc_control_two_reg)
      | ({8{sel_three}} & misc_control_three_reg)
      | ({8{sel_mux}} & input_mux_select_one_reg)
      | ({8{sel_fcs}} & filter_clock_sync_select_reg);

   // field decode
   // chroma pairing mode
   assign chroma_pair_alignment = misc_control_one_reg[ALIGN_BIT];

   assign line_pll_powerdown = misc_control_one_reg[POWERDOWN_BIT];

   assign line_pll_startup_enable = misc_control_one_reg[STARTUP_BIT];

   // misc control two: enables and test code
   wire out_en_n = misc_control_two_reg[OUT_EN_N_BIT];
   wire green_sync_out_enable_n = misc_control_two_reg[GREEN_OUT_EN_N_BIT];
   wire [2:0] test_sel = misc_control_two_reg[TEST_SEL_LSB +: 3];

   // misc control three: polarities and blank enable
   wire out_clock_edge_select = misc_control_three_reg[CLK_EDGE_BIT];
   wire green_sync_out_invert = misc_control_three_reg[GREEN_INV_BIT];
   wire field_flag_invert = misc_control_three_reg[FIELD_INV_BIT];
   wire blank_enable = misc_control_three_reg[BLANK_EN_BIT];

   assign color_convert_enable = misc_control_three_reg[CONVERT_EN_BIT];

   // analog input selectors, green code 11 is the fourth input
   assign blue_input_select = input_mux_select_one_reg[BLUE_SEL_LSB +: 2];
   assign green_input_select = input_mux_select_one_reg[GREEN_SEL_LSB +: 2];
   assign red_input_select = input_mux_select_one_reg[RED_SEL_LSB +: 2];
   assign green_sync_input_select = input_mux_select_one_reg[GSYNC_SEL_LSB +: 2];

   assign green_sync_filter_select = filter_clock_sync_select_reg[GSYNC_LPF_LSB +: 2];

   assign coarse_clamp_filter_select = filter_clock_sync_select_reg[CLAMP_LPF_LSB +: 2];

   // sync reference source; control port stays on internal ref
   assign sync_ref_external = filter_clock_sync_select_reg[CLK_SEL_BIT];

   assign sample_clock_from_pll = filter_clock_sync_select_reg[PCLK_SEL_BIT];
   wire vertical_sync_input_select = filter_clock_sync_select_reg[VSYNC_PICK_BIT];
   wire horizontal_sync_input_select = filter_clock_sync_select_reg[HSYNC_PICK_BIT];

   // sync pins are asynchronous: two flops before any mux reads them
   // vector order: hsync a, hsync b, vsync a, vsync b
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_meta_reg <= 4'h0;
         sync_pin_reg <= 4'h0;
      end else if (clk_en) begin
         sync_meta_reg <= {vsync_b_pin, vsync_a_pin, hsync_b_pin, hsync_a_pin};
         sync_pin_reg <= sync_meta_reg;
      end
   end

   assign selected_hsync = horizontal_sync_input_select ? sync_pin_reg[1] : sync_pin_reg[0];
   assign selected_vsync = vertical_sync_input_select ? sync_pin_reg[3] : sync_pin_reg[2];

   // data enable from active video outside vertical blanking
   wire data_enable = active_video_window & ~vertical_blank_window;
   wire field_flag_next = odd_field ^ field_flag_invert;

   // forced blank level outside data enable with embedded syncs
   wire force_blank = blank_enable & embedded_sync_enable & ~data_enable;
   wire [29:0] video_sel = color_convert_enable ? converted_pixel_in : pixel_in;
   // blank word: chroma in the outer fields, luma in the middle one
   assign pixel_data_next = force_blank ? {BLANK_CHROMA, BLANK_LUMA, BLANK_CHROMA} : video_sel;

   always_comb begin
      case (dmcr_test_sel_e'(test_sel))
         DMCR_TP_FIELD: test_pin_next = field_flag_next;
         // field polarity also inverts data enable
         DMCR_TP_DATA_EN: test_pin_next = data_enable ^ field_flag_invert;
         DMCR_TP_REFCLK: test_pin_next = internal_ref_clock;
         DMCR_TP_COAST: test_pin_next = coast;
         DMCR_TP_CLAMP: test_pin_next = clamp_pulse;
         default: test_pin_next = 1'b0;
      endcase
   end

   // reserved codes and the high impedance code leave the pin undriven
   wire test_pin_drive = test_code_driven(test_sel);

   // video data register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pixel_data_reg <= 30'h0;
      end else if (clk_en) begin
         pixel_data_reg <= pixel_data_next;
      end
   end

   // field flag and discrete sync registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         field_flag_reg <= 1'b0;
         horizontal_sync_reg <= 1'b0;
         vertical_sync_reg <= 1'b0;
         green_sync_reg <= 1'b0;
      end else if (clk_en) begin
         field_flag_reg <= field_flag_next;
         horizontal_sync_reg <= horizontal_sync_proc;
         vertical_sync_reg <= vertical_sync_proc;
         green_sync_reg <= green_sync_proc ^ green_sync_out_invert;
      end
   end

   // test pin register, aligned with the other outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         test_pin_reg <= 1'b0;
      end else if (clk_en) begin
         test_pin_reg <= test_pin_next;
      end
   end

   assign pixel_data_out = pixel_data_reg;
   assign field_flag_output = field_flag_reg;
   assign horizontal_sync_output = horizontal_sync_reg;
   assign vertical_sync_output = vertical_sync_reg;
   assign green_sync_output = green_sync_reg;
   assign test_pin_out = test_pin_reg;
   assign test_pin_oe = test_pin_drive;
   // output clock inverted when the clock edge bit is one, so data changes on the falling edge
   // passed through, not registered, so it keeps the sample clock phase
   assign output_data_clock = sample_clock_phase ^ out_clock_edge_select;

   // shared low-active enable for data, clock, syncs and field
   wire bus_drive = ~out_en_n;
   assign pixel_data_oe = bus_drive;
   assign output_data_clock_oe = bus_drive;
   assign horizontal_sync_oe = bus_drive;
   assign vertical_sync_oe = bus_drive;
   assign field_flag_oe = bus_drive;
   assign green_sync_oe = ~green_sync_out_enable_n;

endmodule
`default_nettype wire

// ===== test/dmcr_monitor.sv
// dmcr_monitor: concurrent checks on the misc control register group.
// assumes it is bound to dmcr_regs and sees only that module's ports.
`default_nettype none
module dmcr_monitor (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic odd_field,
   input wire logic active_video_window,
   input wire logic vertical_blank_window,
   input wire logic green_sync_proc,
   input wire logic sample_clock_phase,
   input wire logic hsync_a_pin,
   input wire logic hsync_b_pin,
   input wire logic selected_hsync,
   input wire logic pixel_data_oe,
   input wire logic horizontal_sync_oe,
   input wire logic green_sync_oe,
   input wire logic field_flag_output,
   input wire logic green_sync_output,
   input wire logic output_data_clock,
   input wire logic test_pin_out,
   input wire logic test_pin_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   logic [7:0] r17, r18, r1a;
   wire wr = reg_write && clk_en;
   // shadow copies of the registers that steer the checked outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         r17 <= 8'h03;
         r18 <= 8'h00;
         r1a <= 8'hc2;
      end else if (wr) begin
         if (reg_addr == 8'h17) r17 <= reg_wdata & 8'h73;
         if (reg_addr == 8'h18) r18 <= reg_wdata & 8'h37;
         if (reg_addr == 8'h1a) r1a <= reg_wdata;
      end
   end
   sequence s_hs_steady;
      clk_en[*2];
   endsequence
   sequence s_data_en_sel;
      clk_en && r17[6:4] == 3'b001;
   endsequence
   chk_bus_oe_gate:
      assert property (pixel_data_oe == !r17[0] && horizontal_sync_oe == pixel_data_oe)
      else $error("bus output enable wrong");
   chk_green_oe_gate:
      assert property (green_sync_oe == !r17[1])
      else $error("green sync output enable wrong");
   chk_test_pin_oe:
      assert property (test_pin_oe == !(r17[6:4] inside {3'b010, 3'b011, 3'b111}))
      else $error("test pin enable wrong");
   chk_field_flag_pol:
      assert property (clk_en |=> field_flag_output == $past(odd_field ^ r18[2]))
      else $error("field flag wrong");
   chk_data_en_pol:
      assert property (s_data_en_sel |=> test_pin_out == $past((active_video_window & ~vertical_blank_window) ^ r18[2]))
      else $error("data enable on test pin wrong");
   chk_green_out_pol:
      assert property (clk_en |=> green_sync_output == $past(green_sync_proc ^ r18[1]))
      else $error("green sync output wrong");
   chk_clock_edge_pol:
      assert property (output_data_clock == (sample_clock_phase ^ r18[0]))
      else $error("output data clock wrong");
   chk_hsync_pick:
      assert property (s_hs_steady |=> selected_hsync ==
         (r1a[0] ? $past(hsync_b_pin, 2) : $past(hsync_a_pin, 2)))
      else $error("horizontal sync pick wrong");
   chk_readback_mask:
      assert property (reg_addr == 8'h18 |-> reg_rdata == r18)
      else $error("readback wrong");
endmodule
`default_nettype wire

// ===== test/digitizer_misc_control_regs_test.sv
// digitizer_misc_control_regs_test: random register and video sweep with queued expectations.
// assumes dmcr_pkg, dmcr_regs and dmcr_monitor are compiled before it.
`default_nettype none
module digitizer_misc_control_regs_test
   import dmcr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int sel; logic [29:0] exp;} dmcr_note_s;
   logic clock, sys_rst, clk_en, reg_write, reg_addr_hit;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v16, v17, v18, v19, v1a;
   logic odd_field, active_video_window, vertical_blank_window, internal_ref_clock, coast, clamp_pulse;
   logic embedded_sync_enable, horizontal_sync_proc, vertical_sync_proc, green_sync_proc, sample_clock_phase;
   logic hsync_a_pin, hsync_b_pin, vsync_a_pin, vsync_b_pin, de;
   logic [29:0] pixel_in, converted_pixel_in, pixel_data_out;
   logic pixel_data_oe, output_data_clock, output_data_clock_oe, horizontal_sync_output, horizontal_sync_oe;
   logic vertical_sync_output, vertical_sync_oe, field_flag_output, field_flag_oe, green_sync_output;
   logic green_sync_oe, test_pin_out, test_pin_oe, chroma_pair_alignment, line_pll_powerdown;
   logic line_pll_startup_enable, color_convert_enable, sync_ref_external, sample_clock_from_pll;
   logic selected_hsync, selected_vsync;
   logic [1:0] green_sync_input_select, red_input_select, green_input_select, blue_input_select;
   logic [1:0] green_sync_filter_select, coarse_clamp_filter_select;
   logic [14:0] rv;
   int error_cnt = 0;
   int n_tests = 0;
   dmcr_note_s notes[$];
   dmcr_note_s nt;
   string nm[8] = '{"rdata", "test_pin", "pixel", "oes", "polarity", "controls", "syncs", "hit"};
   assign {odd_field, active_video_window, vertical_blank_window, internal_ref_clock, coast, clamp_pulse,
      embedded_sync_enable, horizontal_sync_proc, vertical_sync_proc, green_sync_proc, sample_clock_phase,
      hsync_a_pin, hsync_b_pin, vsync_a_pin, vsync_b_pin} = rv;
   dmcr_regs dmcr_regs_inst (.clock, .sys_rst, .clk_en, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
      .reg_addr_hit, .odd_field, .active_video_window, .vertical_blank_window, .internal_ref_clock, .coast,
      .clamp_pulse, .embedded_sync_enable, .horizontal_sync_proc, .vertical_sync_proc, .green_sync_proc,
      .sample_clock_phase, .pixel_in, .converted_pixel_in, .hsync_a_pin, .hsync_b_pin, .vsync_a_pin,
      .vsync_b_pin, .pixel_data_out, .pixel_data_oe, .output_data_clock, .output_data_clock_oe,
      .horizontal_sync_output, .horizontal_sync_oe, .vertical_sync_output, .vertical_sync_oe,
      .field_flag_output, .field_flag_oe, .green_sync_output, .green_sync_oe, .test_pin_out, .test_pin_oe,
      .chroma_pair_alignment, .line_pll_powerdown, .line_pll_startup_enable, .color_convert_enable,
      .green_sync_input_select, .red_input_select, .green_input_select, .blue_input_select,
      .green_sync_filter_select, .coarse_clamp_filter_select, .sync_ref_external, .sample_clock_from_pll,
      .selected_hsync, .selected_vsync);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic check(input string what, input logic [29:0] seen, input logic [29:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic note(input int sel, input logic [29:0] exp);
      notes.push_back('{sel, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock);
      reg_write = 1'b0;
      reg_addr = a;
      note(0, 30'(exp));
   endtask
   function automatic logic [29:0] tp_exp(input logic [2:0] c, input logic inv);
      case (c)
         3'b000: return 30'({1'b1, odd_field ^ inv});
         3'b001: return 30'({1'b1, de ^ inv});
         3'b100: return 30'({1'b1, internal_ref_clock});
         3'b101: return 30'({1'b1, coast});
         3'b110: return 30'({1'b1, clamp_pulse});
         default: return 30'h0;
      endcase
   endfunction
   function automatic logic [29:0] pick(input int s);
      case (s)
         0: return 30'(reg_rdata);
         1: return 30'({test_pin_oe, test_pin_out});
         2: return pixel_data_out;
         3: return 30'({pixel_data_oe, output_data_clock_oe, horizontal_sync_oe, vertical_sync_oe,
            field_flag_oe, green_sync_oe});
         4: return 30'({field_flag_output, green_sync_output, output_data_clock});
         5: return 30'({chroma_pair_alignment, line_pll_powerdown, line_pll_startup_enable, color_convert_enable,
            green_sync_input_select, red_input_select, green_input_select, blue_input_select,
            green_sync_filter_select, coarse_clamp_filter_select, sync_ref_external, sample_clock_from_pll});
         6: return 30'({selected_hsync, selected_vsync, horizontal_sync_output, vertical_sync_output});
         default: return 30'(reg_addr_hit);
      endcase
   endfunction
   // every queued note, oldest first, against what the outputs show now
   always @(posedge clock) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         check(nm[nt.sel], pick(nt.sel), nt.exp);
      end
   end
   initial begin
      #80000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_write = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      rv = 15'h0;
      pixel_in = 30'h0;
      converted_pixel_in = 30'h0;
      void'($urandom(20));
      repeat (3) @(negedge clock);
      sys_rst = 1'b0;
      rd(8'h16, 8'h11);
      rd(8'h17, 8'h03);
      rd(8'h18, 8'h00);
      rd(8'h19, 8'h00);
      rd(8'h1a, 8'hc2);
      rd(8'h1b, 8'h00);
      note(7, 30'h0);
      note(3, 30'h0);
      // a frozen write, then a write to an unmapped place
      clk_en = 1'b0;
      wr(8'h16, 8'h02);
      @(negedge clock);
      clk_en = 1'b1;
      reg_addr = 8'h1b;
      rd(8'h16, 8'h11);
      for (int i = 0; i < 48; i++) begin
         v16 = 8'($urandom);
         v17 = 8'($urandom);
         v17[6:4] = 3'(i);
         v18 = 8'($urandom);
         v19 = 8'($urandom);
         v1a = 8'($urandom);
         wr(8'h16, v16);
         wr(8'h17, v17);
         wr(8'h18, v18);
         wr(8'h19, v19);
         // the clamp source choice lives outside this register group
         wr(8'h1a, v1a);
         @(negedge clock);
         reg_write = 1'b0;
         rv = 15'($urandom);
         pixel_in = 30'($urandom);
         converted_pixel_in = 30'($urandom);
         repeat (3) @(negedge clock);
         de = active_video_window & ~vertical_blank_window;
         note(1, tp_exp(v17[6:4], v18[2]));
         note(2, (v18[5] && embedded_sync_enable && !de) ? {BLANK_CHROMA, BLANK_LUMA, BLANK_CHROMA}
            : (v18[4] ? converted_pixel_in : pixel_in));
         note(3, 30'({{5{~v17[0]}}, ~v17[1]}));
         note(4, 30'({odd_field ^ v18[2], green_sync_proc ^ v18[1], sample_clock_phase ^ v18[0]}));
         note(5, 30'({v16[4], v16[1:0], v18[4], v19, v1a[7:3], v1a[1]}));
         note(6, 30'({v1a[0] ? hsync_b_pin : hsync_a_pin, v1a[2] ? vsync_b_pin : vsync_a_pin,
            horizontal_sync_proc, vertical_sync_proc}));
         note(7, 30'h1);
         rd(8'h16, v16 & 8'h13);
         rd(8'h17, v17 & 8'h73);
         rd(8'h18, v18 & 8'h37);
         rd(8'h19, v19);
         rd(8'h1a, v1a);
      end
      @(negedge clock);
      report_and_stop();
   end
endmodule
bind dmcr_regs dmcr_monitor dmcr_monitor_inst (.clock, .sys_rst, .clk_en, .reg_addr, .reg_write, .reg_wdata,
   .reg_rdata, .odd_field, .active_video_window, .vertical_blank_window, .green_sync_proc, .sample_clock_phase,
   .hsync_a_pin, .hsync_b_pin, .selected_hsync, .pixel_data_oe, .horizontal_sync_oe, .green_sync_oe,
   .field_flag_output,
   .green_sync_output, .output_data_clock, .test_pin_out, .test_pin_oe);
`default_nettype wire
